/* File: design/t2crc_consts.vh */
// register indices, field positions, reset values and timing for the timer block
`ifndef T2CRC_CONSTS_VH
`define T2CRC_CONSTS_VH

// register indices; byte address is four times the index
`define T2CRC_IDX_T0_LOW 8'h8a
`define T2CRC_IDX_T1_LOW 8'h8b
`define T2CRC_IDX_T0_HIGH 8'h8c
`define T2CRC_IDX_T1_HIGH 8'h8d
`define T2CRC_IDX_T2_CTRL 8'hc8
`define T2CRC_IDX_RC_LOW 8'hca
`define T2CRC_IDX_RC_HIGH 8'hcb
`define T2CRC_IDX_T2_LOW 8'hcc
`define T2CRC_IDX_T2_HIGH 8'hcd
`define T2CRC_IDX_T1_CTRL 8'hd0
`define T2CRC_IDX_IRQ_STATUS 8'hd1
`define T2CRC_IDX_IRQ_MASK 8'hd2
`define T2CRC_IDX_AUXILIARY_CONTROL_ONE 8'hf8

// timer2 control fields
`define T2CRC_T2_OVF_FLAG 7
`define T2CRC_T2_EXT_FLAG 6
`define T2CRC_T2_RX_BAUD 5
`define T2CRC_T2_TX_BAUD 4
`define T2CRC_T2_TRIG_EN 3
`define T2CRC_T2_RUN 2
`define T2CRC_T2_CNT_SEL 1
`define T2CRC_T2_CAP_SEL 0

// timer1 control fields
`define T1CTRL_RUN 3
`define T1CTRL_CNT_SEL 2
`define T1CTRL_MODE_HI 1
`define T1CTRL_MODE_LO 0
`define T2CRC_T1_MODE_13BIT 2'h0
`define T2CRC_T1_MODE_16BIT 2'h1
`define T2CRC_T1_MODE_RELOAD 2'h2

// auxiliary control fields
`define T2CRC_AUX_T2_SLOW 2
`define T2CRC_AUX_T1_SLOW 1

// interrupt status bits
`define T2CRC_IRQ_T2_OVF 0
`define T2CRC_IRQ_EXT_EDGE 1
`define T2CRC_IRQ_T1_OVF 2

// reset value and auxiliary write mask
`define T2CRC_RESET_BYTE 8'h00
`define T2CRC_AUX_RW_MASK 8'hdf

// timing
`define T2CRC_TIMER_DIV 1'b1
`define T2CRC_SLOW_DIV_LAST 4'hf

`endif

/* File: design/t2crc_timer.v */
// timer0/1 byte registers, timer1 counting, timer2 capture/reload and baud selection
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "t2crc_consts.vh"

module t2crc_timer
(
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [9:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // pins
    input wire timer1_count_pin_i,
    input wire timer2_count_pin_i,
    input wire external_trigger_pin_i,
    input wire slow_clock_i,
    // baud ticks, timer2 overflow pulse and interrupt
    output reg rx_baud_tick_o,
    output reg tx_baud_tick_o,
    output reg timer2_overflow_o,
    output wire irq_o
);

    // registers
    reg [7:0] timer0_count_low;
    reg [7:0] timer0_count_high;
    reg [7:0] timer1_count_low;
    reg [7:0] timer1_count_high;
    reg [7:0] timer2_control;
    reg [7:0] timer2_reload_capture_low;
    reg [7:0] timer2_reload_capture_high;
    reg [7:0] timer2_count_low;
    reg [7:0] timer2_count_high;
    reg [3:0] timer1_control;
    reg [7:0] auxiliary_control_one;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    // pin synchronisers: 0 t1 pin, 1 t2 pin, 2 trigger, 3 slow clock
    wire [3:0] pin_raw;
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg [3:0] pin_prev;
    wire [3:0] pin_fall;
    reg [3:0] slow_div;
    reg half_tick;
    wire [7:0] reg_idx;
    wire bus_req;
    wire wr_en;
    wire rd_en;
    wire slow16_fall;
    wire t1_edge;
    wire t2_edge;
    wire trig_fall;
    wire baud_mode;
    wire t2_inc;
    wire [15:0] t2_count;
    wire t2_ovf;
    wire trig_act;
    wire do_reload;
    wire do_capture;
    wire [15:0] t2_plus;
    wire [1:0] t1_mode;
    wire t1_inc;
    reg t1_ovf;
    reg [7:0] next_t1_low;
    reg [7:0] next_t1_high;
    reg [7:0] next_t2_low;
    reg [7:0] next_t2_high;
    reg [7:0] rd_data;
    assign pin_raw = {slow_clock_i, external_trigger_pin_i,
                      timer2_count_pin_i, timer1_count_pin_i};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_pin
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    pin_meta[gi] <= 1'b1;
                    pin_sync[gi] <= 1'b1;
                    pin_prev[gi] <= 1'b1;
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_prev[gi] <= pin_sync[gi];
                end
            end
            // falling edge from consecutive synchronised samples
            assign pin_fall[gi] = pin_prev[gi] & ~pin_sync[gi];
        end
    endgenerate

    // slow clock divided by 16, pulse at falling edge of divided clock
    always @(posedge clk_i)
    begin
        if (rst_i)
            slow_div <= 4'h0;
        else if (pin_fall[3])
            slow_div <= slow_div + 4'h1;
    end
    assign slow16_fall = pin_fall[3] & (slow_div == `T2CRC_SLOW_DIV_LAST);
    // timer rate enable: one pulse every two system clocks
    always @(posedge clk_i)
    begin
        if (rst_i)
            half_tick <= 1'b0;
        else
            half_tick <= half_tick ^ `T2CRC_TIMER_DIV;
    end
    assign t1_edge = auxiliary_control_one[`T2CRC_AUX_T1_SLOW] ?
                     slow16_fall : pin_fall[0];
    assign t2_edge = auxiliary_control_one[`T2CRC_AUX_T2_SLOW] ?
                     slow16_fall : pin_fall[1];
    assign trig_fall = pin_fall[2];
    // bus decode
    assign reg_idx = adr_i[9:2];
    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign wr_en = bus_req & we_i & sel_i[0];
    assign rd_en = bus_req & ~we_i;
    // timer1
    assign t1_mode = timer1_control[`T1CTRL_MODE_HI:`T1CTRL_MODE_LO];
    assign t1_inc = timer1_control[`T1CTRL_RUN] &
                    (timer1_control[`T1CTRL_CNT_SEL] ? t1_edge : half_tick);

    always @*
    begin
        next_t1_low = timer1_count_low;
        next_t1_high = timer1_count_high;
        t1_ovf = 1'b0;
        if (t1_inc)
        begin
            case (t1_mode)
                `T2CRC_T1_MODE_13BIT:
                begin
                    next_t1_low = {3'h0, timer1_count_low[4:0] + 5'h01};
                    if (timer1_count_low[4:0] == 5'h1f)
                    begin
                        next_t1_high = timer1_count_high + 8'h01;
                        t1_ovf = (timer1_count_high == 8'hff);
                    end
                end
                `T2CRC_T1_MODE_16BIT:
                begin
                    next_t1_low = timer1_count_low + 8'h01;
                    if (timer1_count_low == 8'hff)
                    begin
                        next_t1_high = timer1_count_high + 8'h01;
                        t1_ovf = (timer1_count_high == 8'hff);
                    end
                end
                `T2CRC_T1_MODE_RELOAD:
                begin
                    if (timer1_count_low == 8'hff)
                    begin
                        next_t1_low = timer1_count_high;
                        t1_ovf = 1'b1;
                    end
                    else
                        next_t1_low = timer1_count_low + 8'h01;
                end
                default: next_t1_low = timer1_count_low;
            endcase
        end
        if (wr_en && reg_idx == `T2CRC_IDX_T1_LOW)
            next_t1_low = dat_i[7:0];
        if (wr_en && reg_idx == `T2CRC_IDX_T1_HIGH)
            next_t1_high = dat_i[7:0];
    end

    // timer2
    assign baud_mode = timer2_control[`T2CRC_T2_RX_BAUD] | timer2_control[`T2CRC_T2_TX_BAUD];
    assign t2_count = {timer2_count_high, timer2_count_low};
    assign t2_plus = t2_count + 16'h0001;
    assign t2_inc = timer2_control[`T2CRC_T2_RUN] &
                    (timer2_control[`T2CRC_T2_CNT_SEL] ? t2_edge : half_tick);
    assign t2_ovf = t2_inc & (t2_count == 16'hffff);
    // trigger acts only when enabled and outside baud mode
    assign trig_act = trig_fall & timer2_control[`T2CRC_T2_TRIG_EN] & ~baud_mode;
    assign do_reload = (t2_ovf & (baud_mode | ~timer2_control[`T2CRC_T2_CAP_SEL])) |
                       (trig_act & ~timer2_control[`T2CRC_T2_CAP_SEL]);
    assign do_capture = trig_act & timer2_control[`T2CRC_T2_CAP_SEL];
    always @*
    begin
        next_t2_low = timer2_count_low;
        next_t2_high = timer2_count_high;
        if (do_reload)
        begin
            next_t2_low = timer2_reload_capture_low;
            next_t2_high = timer2_reload_capture_high;
        end
        else if (t2_inc)
        begin
            next_t2_low = t2_plus[7:0];
            next_t2_high = t2_plus[15:8];
        end
        if (wr_en && reg_idx == `T2CRC_IDX_T2_LOW)
            next_t2_low = dat_i[7:0];
        if (wr_en && reg_idx == `T2CRC_IDX_T2_HIGH)
            next_t2_high = dat_i[7:0];
    end
    // read mux
    always @*
    begin
        case (reg_idx)
            `T2CRC_IDX_T0_LOW: rd_data = timer0_count_low;
            `T2CRC_IDX_T1_LOW: rd_data = timer1_count_low;
            `T2CRC_IDX_T0_HIGH: rd_data = timer0_count_high;
            `T2CRC_IDX_T1_HIGH: rd_data = timer1_count_high;
            `T2CRC_IDX_T2_CTRL: rd_data = timer2_control;
            `T2CRC_IDX_RC_LOW: rd_data = timer2_reload_capture_low;
            `T2CRC_IDX_RC_HIGH: rd_data = timer2_reload_capture_high;
            `T2CRC_IDX_T2_LOW: rd_data = timer2_count_low;
            `T2CRC_IDX_T2_HIGH: rd_data = timer2_count_high;
            `T2CRC_IDX_T1_CTRL: rd_data = {4'h0, timer1_control};
            `T2CRC_IDX_IRQ_STATUS: rd_data = {5'h00, irq_status};
            `T2CRC_IDX_IRQ_MASK: rd_data = {5'h00, irq_mask};
            `T2CRC_IDX_AUXILIARY_CONTROL_ONE: rd_data = auxiliary_control_one;
            default: rd_data = 8'h00;
        endcase
    end

    // bus answer one cycle after request
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end
        else
        begin
            ack_o <= bus_req;
            if (rd_en)
                dat_o <= {24'h000000, rd_data};
        end
    end

    // counters and plain registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer0_count_low <= `T2CRC_RESET_BYTE;
            timer0_count_high <= `T2CRC_RESET_BYTE;
            timer1_count_low <= `T2CRC_RESET_BYTE;
            timer1_count_high <= `T2CRC_RESET_BYTE;
            timer2_count_low <= `T2CRC_RESET_BYTE;
            timer2_count_high <= `T2CRC_RESET_BYTE;
            timer2_reload_capture_low <= `T2CRC_RESET_BYTE;
            timer2_reload_capture_high <= `T2CRC_RESET_BYTE;
            timer1_control <= 4'h0;
            auxiliary_control_one <= `T2CRC_RESET_BYTE;
            irq_mask <= 3'h0;
        end
        else
        begin
            if (wr_en && reg_idx == `T2CRC_IDX_T0_LOW)
                timer0_count_low <= dat_i[7:0];
            if (wr_en && reg_idx == `T2CRC_IDX_T0_HIGH)
                timer0_count_high <= dat_i[7:0];
            timer1_count_low <= next_t1_low;
            timer1_count_high <= next_t1_high;
            timer2_count_low <= next_t2_low;
            timer2_count_high <= next_t2_high;
            if (wr_en && reg_idx == `T2CRC_IDX_RC_LOW)
                timer2_reload_capture_low <= dat_i[7:0];
            else if (do_capture)
                timer2_reload_capture_low <= timer2_count_low;
            if (wr_en && reg_idx == `T2CRC_IDX_RC_HIGH)
                timer2_reload_capture_high <= dat_i[7:0];
            else if (do_capture)
                timer2_reload_capture_high <= timer2_count_high;
            if (wr_en && reg_idx == `T2CRC_IDX_T1_CTRL)
                timer1_control <= dat_i[3:0];
            if (wr_en && reg_idx == `T2CRC_IDX_AUXILIARY_CONTROL_ONE)
                auxiliary_control_one <= dat_i[7:0] & `T2CRC_AUX_RW_MASK;
            if (wr_en && reg_idx == `T2CRC_IDX_IRQ_MASK)
                irq_mask <= dat_i[2:0];
        end
    end

    // timer2 control with hardware flags; a set beats a software clear
    always @(posedge clk_i)
    begin
        if (rst_i)
            timer2_control <= `T2CRC_RESET_BYTE;
        else
        begin
            if (wr_en && reg_idx == `T2CRC_IDX_T2_CTRL)
                timer2_control <= dat_i[7:0];
            if (t2_ovf && !baud_mode)
                timer2_control[`T2CRC_T2_OVF_FLAG] <= 1'b1;
            if (trig_act)
                timer2_control[`T2CRC_T2_EXT_FLAG] <= 1'b1;
        end
    end

    // sticky interrupt status, cleared by read, set wins
    always @(posedge clk_i)
    begin
        if (rst_i)
            irq_status <= 3'h0;
        else
        begin
            if (rd_en && reg_idx == `T2CRC_IDX_IRQ_STATUS)
                irq_status <= 3'h0;
            if (t2_ovf && !baud_mode)
                irq_status[`T2CRC_IRQ_T2_OVF] <= 1'b1;
            if (trig_act)
                irq_status[`T2CRC_IRQ_EXT_EDGE] <= 1'b1;
            if (t1_ovf)
                irq_status[`T2CRC_IRQ_T1_OVF] <= 1'b1;
        end
    end

    assign irq_o = |(irq_status & irq_mask);

    // baud clock sources
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_baud_tick_o <= 1'b0;
            tx_baud_tick_o <= 1'b0;
            timer2_overflow_o <= 1'b0;
        end
        else
        begin
            rx_baud_tick_o <= timer2_control[`T2CRC_T2_RX_BAUD] ? t2_ovf : t1_ovf;
            tx_baud_tick_o <= timer2_control[`T2CRC_T2_TX_BAUD] ? t2_ovf : t1_ovf;
            timer2_overflow_o <= t2_ovf;
        end
    end

endmodule

/* File: tb/t2crc_timer_assertions.sv */
// port checker for the timer block
`timescale 1ns/1ps
module t2crc_chk
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // ticks and interrupt
    input wire logic rx_baud_tick_o,
    input wire logic tx_baud_tick_o,
    input wire logic timer2_overflow_o,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ans;
        ack_o ##1 !ack_o;
    endsequence
    property p_ack;
        s_req |=> s_ans;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack pulse");
    property p_idle;
        !cyc_i |=> !ack_o;
    endproperty
    a_idle: assert property (p_idle) else $error("ack without request");
    property p_hold;
        !(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_upper;
        dat_o[31:8] == 24'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper data set");
    property p_reset;
        $fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0 && !timer2_overflow_o;
    endproperty
    a_reset: assert property (p_reset) else $error("not quiet after reset");
    property p_rx;
        rx_baud_tick_o |=> !rx_baud_tick_o;
    endproperty
    a_rx: assert property (p_rx) else $error("rx tick too long");
    property p_tx;
        tx_baud_tick_o |=> !tx_baud_tick_o;
    endproperty
    a_tx: assert property (p_tx) else $error("tx tick too long");
    property p_ovf;
        timer2_overflow_o |=> !timer2_overflow_o;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow pulse too long");
endmodule

bind t2crc_timer t2crc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o),
    .timer2_overflow_o(timer2_overflow_o), .irq_o(irq_o));

/* File: tb/t2crc_pins.sv */
// far-side model: count pins, trigger pin and slow clock
`timescale 1ns/1ps
module t2crc_pins
(
    // clock
    input wire logic clk_i,
    // pins
    output logic timer1_count_pin_o,
    output logic timer2_count_pin_o,
    output logic external_trigger_pin_o,
    output logic slow_clock_o
);
    logic [3:0] pins = 4'hf;
    assign timer1_count_pin_o = pins[0];
    assign timer2_count_pin_o = pins[1];
    assign external_trigger_pin_o = pins[2];
    assign slow_clock_o = pins[3];
    // n falling edges on pin k, low held 4 clocks, high held 5 clocks between edges
    task automatic fall(input int k, input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            pins[k] <= 1'b0;
            repeat (4) @(posedge clk_i);
            pins[k] <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
    endtask
endmodule

/* File: tb/timer2_capture_reload_counter_tb.sv */
// self-checking bench for the timer block
`timescale 1ns/1ps
`include "t2crc_consts.vh"
module timer2_capture_reload_counter_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [9:0] adr_i = 10'h0;
    logic [31:0] dat_i = 32'h0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_o;
    logic ack_o, rx_baud_tick_o, tx_baud_tick_o, timer2_overflow_o, irq_o, p1, p2, pt, ps;
    int errors = 0;
    int tests_run = 0;
    int mdl [256];
    logic [7:0] regs [8] = '{8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    logic [7:0] q, c;
    always #12.5 clk_i = ~clk_i;
    t2crc_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .timer1_count_pin_i(p1), .timer2_count_pin_i(p2),
        .external_trigger_pin_i(pt), .slow_clock_i(ps), .rx_baud_tick_o(rx_baud_tick_o),
        .tx_baud_tick_o(tx_baud_tick_o), .timer2_overflow_o(timer2_overflow_o),
        .irq_o(irq_o));
    t2crc_pins u_pins (.clk_i(clk_i), .timer1_count_pin_o(p1), .timer2_count_pin_o(p2),
        .external_trigger_pin_o(pt), .slow_clock_o(ps));
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [7:0] r);
        int t;
        t = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, i, 2'b00, 24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++t < 50);
        r = dat_o[7:0];
        {cyc_i, stb_i} <= 2'b00;
        chk("ack", t < 50, 1);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, i, d, r);
        mdl[i] = d;
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] r);
        wb(1'b0, i, 8'h0, r);
    endtask
    task automatic hold_for(input int w);
        int t;
        t = 0;
        do @(posedge clk_i);
        while ((w ? rx_baud_tick_o : timer2_overflow_o) !== 1'b1 && ++t < 200);
        chk("tick wait", t < 200, 1);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        print_verdict();
    end
    initial
    begin
        c = 8'($urandom(93));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (regs[k])
        begin
            rd(regs[k], q);
            chk("reset", q, 0);
            c = 8'($urandom);
            wr(regs[k], c);
            rd(regs[k], q);
            chk("rw", q, 16'(mdl[regs[k]]));
        end
        sel_i <= 4'he;
        wb(1'b1, 8'h8a, 8'h5a, q);
        sel_i <= 4'hf;
        rd(8'h8a, q);
        chk("byte lane", q, 16'(mdl[8'h8a]));
        wr(8'hf8, 8'hff);
        rd(8'hf8, q);
        chk("aux", q, `T2CRC_AUX_RW_MASK);
        wr(8'hf8, 8'h00);
        rd(8'h40, q);
        chk("unmapped", q, 0);
        $display("registers done");
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'hc8, 8'h04);
        repeat (200) @(posedge clk_i);
        wr(8'hc8, 8'h00);
        rd(8'hcc, q);
        repeat (20) @(posedge clk_i);
        rd(8'hcc, c);
        chk("rate", q >= 100 && q <= 103, 1);
        chk("held", c, q);
        $display("rate done");
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcd, 8'hff);
        wr(8'hcc, 8'hf0);
        wr(8'hc8, 8'h04);
        hold_for(0);
        chk("masked", irq_o, 0);
        wr(8'hd2, 8'h01);
        chk("irq", irq_o, 1);
        rd(8'hd1, q);
        chk("status", q[0], 1);
        chk("irq clear", irq_o, 0);
        rd(8'hc8, q);
        chk("ovf flag", q, 8'h84);
        wr(8'hc8, 8'h00);
        rd(8'hcd, q);
        chk("reload hi", q, 8'h12);
        rd(8'hcc, q);
        chk("reload lo", q >= 8'h34 && q < 8'h40, 1);
        $display("overflow done");
        wr(8'hc8, 8'h05);
        u_pins.fall(2, 1);
        rd(8'hc8, q);
        chk("trigger off", q, 8'h05);
        wr(8'hc8, 8'h0d);
        u_pins.fall(2, 1);
        rd(8'hc8, q);
        chk("edge flag", q, 8'h4d);
        wr(8'hc8, 8'h01);
        rd(8'hca, q);
        rd(8'hcc, c);
        chk("capture", q > 8'h40 && q < c, 1);
        $display("capture done");
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hcd, 8'hff);
        wr(8'hcc, 8'hf0);
        wr(8'hc8, 8'h35);
        hold_for(1);
        chk("tx tick", tx_baud_tick_o, 1);
        rd(8'hcd, q);
        chk("forced reload", q, 8'hff);
        rd(8'hc8, q);
        chk("no flag", q, 8'h35);
        wr(8'hc8, 8'h24);
        hold_for(1);
        chk("tx from timer1", tx_baud_tick_o, 0);
        wr(8'hc8, 8'h00);
        $display("baud done");
        for (int j = 0; j < 2; j++)
        begin
            wr(8'h8d, j ? 8'hfe : 8'hff);
            wr(8'h8b, 8'hfc);
            wr(8'hd0, j ? 8'h0a : 8'h08);
            hold_for(1);
            chk("t1 tx tick", tx_baud_tick_o, 1);
            wr(8'hd0, 8'h00);
            rd(8'h8d, q);
            chk("t1 high", q, j ? 8'hfe : 8'h00);
        end
        $display("timer1 done");
        for (int j = 0; j < 2; j++)
        begin
            wr(j ? 8'h8b : 8'hcc, 8'h00);
            wr(j ? 8'hd0 : 8'hc8, j ? 8'h0d : 8'h06);
            wr(8'hf8, j ? 8'h02 : 8'h04);
            u_pins.fall(j ? 0 : 1, 2);
            u_pins.fall(3, 16);
            wr(8'hf8, 8'h00);
            u_pins.fall(j ? 0 : 1, 3);
            rd(j ? 8'h8b : 8'hcc, q);
            chk("count input", q, 4);
            wr(j ? 8'hd0 : 8'hc8, 8'h00);
        end
        $display("counter done");
        print_verdict();
    end
endmodule
